/* hdl/flash_latency_pkg.sv */
// How it works
// - code 11b serves clocks up to 50 MHz
// - 11b: single and multi-out reads, no wait
// - 11b: dual io read, four dummy cycles
// - 11b: quad io, two mode, one dummy
// - 00b, 80 MHz: normal refused, fast and multi-out eight
// - 00b: dual io four, quad io two+four
// - 01b, 90 MHz: eight, five, two+four
// - 10b, 104 MHz: eight, six, two+five
// - 10b above 104 MHz: fast read only
// - host never issues unsupported table entries
package flash_latency_pkg;

  // read command kinds
  typedef enum logic [2:0] {
    RD_NORMAL   = 3'h0,
    RD_FAST     = 3'h1,
    RD_DUAL_OUT = 3'h2,
    RD_QUAD_OUT = 3'h3,
    RD_DUAL_IO  = 3'h4,
    RD_QUAD_IO  = 3'h5
  } read_cmd_t;

  localparam int         NUM_CMDS  = 6;
  localparam int         NUM_ROWS  = 5;
  localparam int         CLK_KHZ   = 50000;
  localparam int         KHZ_PER_MHZ = 1000;
  localparam logic [7:0] NO_SUPPORT = 8'hff;
  localparam logic [7:0] CMD_BITS  = 8'h08;
  localparam logic [7:0] ADDR_BITS = 8'h18;
  localparam logic [7:0] HDR_BITS  = 8'h20;
  localparam logic [7:0] DATA_BITS = 8'h08;
  localparam logic [7:0] CONTENT_SEED = 8'h5a;
  localparam logic [2:0] ROW_104   = 3'h3;
  localparam logic [2:0] ROW_133   = 3'h4;

  // one row per sck band, in band order
  localparam logic [7:0] ROW_MHZ [0:4] = '{8'h32, 8'h50, 8'h5a, 8'h68, 8'h85};

  // cycle tables: columns follow read_cmd_t
  localparam logic [7:0] MODE_CYC [0:4][0:5] = '{
    '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02},
    '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02},
    '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02},
    '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02},
    '{8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff}};
  localparam logic [7:0] LAT_CYC [0:4][0:5] = '{
    '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h01},
    '{8'hff, 8'h08, 8'h08, 8'h08, 8'h04, 8'h04},
    '{8'hff, 8'h08, 8'h08, 8'h08, 8'h05, 8'h04},
    '{8'hff, 8'h08, 8'h08, 8'h08, 8'h06, 8'h05},
    '{8'hff, 8'h08, 8'hff, 8'hff, 8'hff, 8'hff}};

  // opcode byte sent for each command kind
  localparam logic [7:0] OPCODE [0:5] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16};

  // table row from latency code and sck rate
  function automatic logic [2:0] row_of(input logic [1:0] code, input int sck_khz);
    unique case (code)
      2'h3: row_of = 3'h0;
      2'h0: row_of = 3'h1;
      2'h1: row_of = 3'h2;
      2'h2: row_of = (sck_khz > int'(ROW_MHZ[ROW_104]) * KHZ_PER_MHZ) ? ROW_133 : ROW_104;
    endcase
  endfunction

  function automatic logic supported(input logic [2:0] row, input logic [2:0] cmd);
    supported = (MODE_CYC[row][cmd] != NO_SUPPORT) && (LAT_CYC[row][cmd] != NO_SUPPORT);
  endfunction

  // lanes used by address and by data
  function automatic logic [2:0] addr_w(input logic [2:0] cmd);
    addr_w = (cmd == RD_QUAD_IO) ? 3'h4 : (cmd == RD_DUAL_IO) ? 3'h2 : 3'h1;
  endfunction

  function automatic logic [2:0] data_w(input logic [2:0] cmd);
    unique case (cmd)
      RD_DUAL_OUT, RD_DUAL_IO: data_w = 3'h2;
      RD_QUAD_OUT, RD_QUAD_IO: data_w = 3'h4;
      default:                 data_w = 3'h1;
    endcase
  endfunction

  // msb-first bits onto lanes; single lane is io0 or io1
  function automatic logic [3:0] lane_out(input logic [3:0] top, input logic [2:0] w, input logic on_io1);
    unique case (w)
      3'h4:    lane_out = top;
      3'h2:    lane_out = {2'h0, top[3:2]};
      default: lane_out = on_io1 ? {2'h0, top[3], 1'b0} : {3'h0, top[3]};
    endcase
  endfunction

  function automatic logic [3:0] lane_oe(input logic [2:0] w, input logic on_io1);
    unique case (w)
      3'h4:    lane_oe = 4'hf;
      3'h2:    lane_oe = 4'h3;
      default: lane_oe = on_io1 ? 4'h2 : 4'h1;
    endcase
  endfunction

  // lanes into low w bits, msb first
  function automatic logic [3:0] lane_in(input logic [3:0] io, input logic [2:0] w, input logic on_io1);
    unique case (w)
      3'h4:    lane_in = io;
      3'h2:    lane_in = {2'h0, io[1:0]};
      default: lane_in = {3'h0, on_io1 ? io[1] : io[0]};
    endcase
  endfunction

endpackage

/* hdl/flash_link.sv */
`timescale 1ns/1ps
`default_nettype none
// serial flash link: clock, select, four shared data lanes
interface flash_link;
  logic       sck;
  logic       cs_n;
  logic [3:0] host_out;
  logic [3:0] host_oe;
  logic [3:0] dev_out;
  logic [3:0] dev_oe;
  logic [3:0] io;

  // lane level: driver wins, idle lanes pull high
  assign io = (host_oe & host_out) | (dev_oe & dev_out) | ~(host_oe | dev_oe);

  modport host (output sck, cs_n, host_out, host_oe, input io);
  modport device (input sck, cs_n, io, output dev_out, dev_oe);
endinterface
`default_nettype wire

/* hdl/flash_read_device.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_read_device
  import flash_latency_pkg::*;
(
  input  wire logic       ref_clk,  // system clock
  input  wire logic       rst_n,    // async reset, low
  input  wire logic [1:0] lat_code, // selected latency code
  flash_link.device       link,     // flash pins
  output logic            active,   // frame selected
  output logic [2:0]      last_cmd  // last accepted command
);

  typedef enum logic [5:0] {
    D_IDLE = 6'b000001,
    D_CMD  = 6'b000010,
    D_ADDR = 6'b000100,
    D_WAIT = 6'b001000,
    D_DATA = 6'b010000,
    D_SKIP = 6'b100000
  } dev_state_t;

  localparam logic [5:0] PIN_IDLE = 6'h2f;

  logic [5:0]  s1, s2, s3, pin;
  logic        sck_prev;
  dev_state_t  state;
  logic [7:0]  cnt, need;
  logic [23:0] sr, addr;
  logic [7:0]  dsr;
  logic [2:0]  cmd, aw, dw;
  logic        rise, fall;
  logic [2:0]  row;
  logic [7:0]  op;
  logic [23:0] next_sr;
  logic [7:0]  byte_now, byte_after, next_dsr;

  // memory content pattern by address
  function automatic logic [7:0] byte_at(input logic [23:0] a);
    byte_at = a[7:0] ^ a[15:8] ^ CONTENT_SEED;
  endfunction

  // three-stage pin sync, level moves once stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1       <= PIN_IDLE;
      s2       <= PIN_IDLE;
      s3       <= PIN_IDLE;
      pin      <= PIN_IDLE;
      sck_prev <= 1'b0;
    end else begin
      s1       <= {link.cs_n, link.sck, link.io};
      s2       <= s1;
      s3       <= s2;
      pin      <= ((s2 ~^ s3) & s3) | ((s2 ^ s3) & pin);
      sck_prev <= pin[4];
    end
  end

  assign rise    = pin[4] & ~sck_prev;
  assign fall    = ~pin[4] & sck_prev;
  assign op      = {sr[6:0], pin[0]};
  assign next_sr = (sr << aw) | {20'h0, lane_in(pin[3:0], aw, 1'b0)};
  assign row     = row_of(lat_code, 0);

  // byte at this and the following address, and the data shifted on
  assign byte_now   = byte_at(addr);
  assign byte_after = byte_at(addr + 24'h1);
  assign next_dsr   = dsr << dw;

  // frame decode, wait count and data drive
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= D_IDLE;
      cnt          <= 8'h00;
      need         <= 8'h00;
      sr           <= 24'h0;
      addr         <= 24'h0;
      dsr          <= 8'h00;
      cmd          <= RD_NORMAL;
      aw           <= 3'h1;
      dw           <= 3'h1;
      link.dev_out <= 4'h0;
      link.dev_oe  <= 4'h0;
      active       <= 1'b0;
      last_cmd     <= 3'h0;
    end else if (pin[5]) begin
      state       <= D_IDLE;
      link.dev_oe <= 4'h0;
      active      <= 1'b0;
    end else begin
      active <= 1'b1;
      unique case (state)
        D_IDLE: begin
          state <= D_CMD;
          cnt   <= 8'h00;
        end
        D_CMD: if (rise) begin
          sr  <= {sr[22:0], pin[0]};
          cnt <= cnt + 8'h01;
          if (cnt == CMD_BITS - 8'h01) begin
            state <= D_SKIP;
            cnt   <= 8'h00;
            for (int i = 0; i < NUM_CMDS; i++) begin
              if (op == OPCODE[i] && supported(row, 3'(i))) begin
                state <= D_ADDR;
                cmd   <= 3'(i);
                aw    <= addr_w(3'(i));
                dw    <= data_w(3'(i));
                need  <= MODE_CYC[row][i] + LAT_CYC[row][i];
              end
            end
          end
        end
        D_ADDR: if (rise) begin
          sr  <= next_sr;
          cnt <= cnt + {5'h0, aw};
          if (cnt + {5'h0, aw} == ADDR_BITS) begin
            addr     <= next_sr;
            state    <= D_WAIT;
            cnt      <= 8'h00;
            last_cmd <= cmd;
          end
        end
        D_WAIT: begin
          if (rise && cnt != need) begin
            cnt <= cnt + 8'h01;
          end else if (fall && cnt == need) begin
            dsr          <= byte_now;
            link.dev_out <= lane_out(byte_now[7:4], dw, 1'b1);
            link.dev_oe  <= lane_oe(dw, 1'b1);
            cnt          <= {5'h0, dw};
            state        <= D_DATA;
          end
        end
        D_DATA: if (fall) begin
          if (cnt == DATA_BITS) begin
            addr         <= addr + 24'h1;
            dsr          <= byte_after;
            link.dev_out <= lane_out(byte_after[7:4], dw, 1'b1);
            cnt          <= {5'h0, dw};
          end else begin
            dsr          <= next_dsr;
            link.dev_out <= lane_out(next_dsr[7:4], dw, 1'b1);
            cnt          <= cnt + {5'h0, dw};
          end
        end
        D_SKIP: cnt <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

/* hdl/flash_read_host.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_read_host
  import flash_latency_pkg::*;
#(
  parameter int SCK_DIV = 12
)
(
  input  wire logic        ref_clk,  // system clock
  input  wire logic        rst_n,    // async reset, low
  input  wire logic [1:0]  lat_code, // latency code in force
  input  wire logic        req,      // start one read
  input  wire logic [2:0]  cmd,      // read kind
  input  wire logic [23:0] addr,     // byte address
  flash_link.host          link,     // flash pins
  output logic             busy,     // read under way
  output logic             done,     // rd_data valid pulse
  output logic             refused,  // request refused pulse
  output logic [7:0]       rd_data   // byte read
);

  typedef enum logic [6:0] {
    H_IDLE  = 7'b0000001,
    H_SEND  = 7'b0000010,
    H_MODE  = 7'b0000100,
    H_DUMMY = 7'b0001000,
    H_DATA  = 7'b0010000,
    H_TRAIL = 7'b0100000,
    H_GAP   = 7'b1000000
  } host_state_t;

  // serial clock rate this host produces
  localparam int         SCK_KHZ  = CLK_KHZ / (2 * SCK_DIV);
  localparam logic [7:0] DIV_LAST = 8'(SCK_DIV - 1);
  localparam logic [3:0] IO_IDLE  = 4'hf;

  host_state_t state;
  logic [7:0]  div_cnt;
  logic        run;
  logic        tick, rise_t, fall_t;
  logic [3:0]  s1, s2, s3, io_s;
  logic [31:0] sr;
  logic [7:0]  bits, cnt;
  logic [7:0]  mode_n, lat_n;
  logic [2:0]  aw, dw, last_w;
  logic [7:0]  rsr;
  logic [2:0]  row;
  logic        ok;
  logic [31:0] next_sr;
  logic [2:0]  next_w;

  // sck divider, runs only inside a frame
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 8'h00;
    end else if (!run || tick) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  assign tick   = run && (div_cnt == DIV_LAST);
  assign rise_t = tick && !link.sck;
  assign fall_t = tick && link.sck;

  // lane inputs pass three stages, level moves when two and three agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1   <= IO_IDLE;
      s2   <= IO_IDLE;
      s3   <= IO_IDLE;
      io_s <= IO_IDLE;
    end else begin
      s1   <= link.io;
      s2   <= s1;
      s3   <= s2;
      io_s <= ((s2 ~^ s3) & s3) | ((s2 ^ s3) & io_s);
    end
  end

  assign row = row_of(lat_code, SCK_KHZ);
  assign ok = (cmd < 3'(NUM_CMDS)) && supported(row, cmd)
              && (int'(ROW_MHZ[row]) * KHZ_PER_MHZ >= SCK_KHZ);

  // header shift: next lane width after the bits already sent
  assign next_sr = sr << last_w;
  assign next_w  = (bits < CMD_BITS) ? 3'h1 : aw;

  // frame sequencer and pins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state         <= H_IDLE;
      run           <= 1'b0;
      link.sck      <= 1'b0;
      link.cs_n     <= 1'b1;
      link.host_out <= 4'h0;
      link.host_oe  <= 4'h0;
      sr            <= 32'h0;
      bits          <= 8'h00;
      cnt           <= 8'h00;
      mode_n        <= 8'h00;
      lat_n         <= 8'h00;
      aw            <= 3'h1;
      dw            <= 3'h1;
      last_w        <= 3'h1;
      rsr           <= 8'h00;
      busy          <= 1'b0;
      done          <= 1'b0;
      refused       <= 1'b0;
      rd_data       <= 8'h00;
    end else begin
      done    <= 1'b0;
      refused <= 1'b0;
      if (tick) begin
        link.sck <= ~link.sck;
      end
      unique case (state)
        H_IDLE: if (req) begin
          if (ok) begin
            // drop select, first command bit already on io0
            state         <= H_SEND;
            busy          <= 1'b1;
            run           <= 1'b1;
            link.cs_n     <= 1'b0;
            sr            <= {OPCODE[cmd], addr};
            link.host_out <= lane_out(OPCODE[cmd][7:4], 3'h1, 1'b0);
            link.host_oe  <= lane_oe(3'h1, 1'b0);
            bits          <= 8'h00;
            aw            <= addr_w(cmd);
            dw            <= data_w(cmd);
            mode_n        <= MODE_CYC[row][cmd];
            lat_n         <= LAT_CYC[row][cmd];
          end else begin
            refused <= 1'b1;
          end
        end
        H_SEND: begin
          if (rise_t) begin
            bits   <= bits + {5'h0, next_w};
            last_w <= next_w;
          end else if (fall_t) begin
            cnt <= 8'h00;
            if (bits == HDR_BITS) begin
              if (mode_n != 8'h00) begin
                state         <= H_MODE;
                link.host_out <= 4'h0;
                link.host_oe  <= lane_oe(aw, 1'b0);
              end else begin
                state        <= (lat_n != 8'h00) ? H_DUMMY : H_DATA;
                link.host_oe <= 4'h0;
              end
            end else begin
              sr            <= next_sr;
              link.host_out <= lane_out(next_sr[31:28], next_w, 1'b0);
              link.host_oe  <= lane_oe(next_w, 1'b0);
            end
          end
        end
        // drive exactly the mode clocks
        H_MODE: begin
          if (rise_t) begin
            cnt <= cnt + 8'h01;
          end else if (fall_t && cnt == mode_n) begin
            cnt          <= 8'h00;
            link.host_oe <= 4'h0;
            state        <= (lat_n != 8'h00) ? H_DUMMY : H_DATA;
          end
        end
        // lanes released for the dummy clocks
        H_DUMMY: begin
          if (rise_t) begin
            cnt <= cnt + 8'h01;
          end else if (fall_t && cnt == lat_n) begin
            cnt   <= 8'h00;
            state <= H_DATA;
          end
        end
        // sample data on rising edges
        H_DATA: begin
          if (rise_t) begin
            rsr <= 8'((rsr << dw) | {4'h0, lane_in(io_s, dw, 1'b1)});
            cnt <= cnt + {5'h0, dw};
          end else if (fall_t && cnt == DATA_BITS) begin
            state     <= H_TRAIL;
            run       <= 1'b0;
            link.cs_n <= 1'b1;
            rd_data   <= rsr;
            done      <= 1'b1;
            cnt       <= 8'h00;
          end
        end
        // hold select high one half period so the far end sees it
        H_TRAIL: begin
          cnt <= cnt + 8'h01;
          if (cnt == DIV_LAST) begin
            state <= H_GAP;
          end
        end
        // one more cycle then ready
        H_GAP: begin
          busy  <= 1'b0;
          state <= H_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* verification/flash_link_props.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_link_props #(
  parameter int HALF = 12          // sck half period in ref_clk cycles
) (
  input  wire logic       ref_clk, // system clock
  input  wire logic       rst_n,   // async reset, low
  input  wire logic       sck,     // serial clock
  input  wire logic       cs_n,    // select, low
  input  wire logic [3:0] host_oe, // host lane enables
  input  wire logic [3:0] dev_oe,  // device lane enables
  input  wire logic [3:0] io       // resolved lane levels
);
  // one domain: all checks on the system clock, off during reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic [7:0] hold_cnt;
  logic       sck_d;

  // cycles since sck last changed, saturating
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt <= 8'h00;
      sck_d    <= 1'b0;
    end else begin
      sck_d    <= sck;
      if (sck != sck_d) begin
        hold_cnt <= 8'h01;
      end else if (hold_cnt != 8'hff) begin
        hold_cnt <= hold_cnt + 8'h01;
      end
    end
  end

  // lane ownership and idle levels
  no_contention_a: assert property ((host_oe & dev_oe) == 4'h0)
    else $error("host and device drive a lane together");
  idle_pullup_a: assert property ((host_oe | dev_oe) == 4'h0 |-> io == 4'hf)
    else $error("released lanes not pulled high");
  host_lanes_a: assert property (host_oe inside {4'h0, 4'h1, 4'h3, 4'hf})
    else $error("host lane enable pattern illegal");
  dev_lanes_a: assert property (dev_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("device lane enable pattern illegal");
  // frame edges and spacing; start, gap and release windows eight cycles each
  opcode_lane_a: assert property ($fell(cs_n) |-> host_oe == 4'h1 && !sck [*8])
    else $error("frame start not on io0 with sck low");
  sck_idle_a: assert property (cs_n |-> !sck && host_oe == 4'h0)
    else $error("sck or host lanes active outside a frame");
  frame_gap_a: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("deselect gap too short");
  sck_half_a: assert property ($fell(sck) |-> hold_cnt == 8'(HALF))
    else $error("sck high half not one half period");
  dev_release_a: assert property (cs_n [*8] |-> dev_oe == 4'h0)
    else $error("device still drives after deselect");

  // main scenarios reached
  frame_c: cover property ($fell(cs_n));
  dual_data_c: cover property (dev_oe == 4'h3);
  quad_data_c: cover property (dev_oe == 4'hf);
endmodule
`default_nettype wire

/* verification/spi_flash_read_latency_select_test.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_flash_read_latency_select_test;
  import flash_latency_pkg::*;
  localparam int DIV = 12; // half period covering both syncs and the device reply

  logic        ref_clk = 1'b0;
  logic        rst_n;
  logic [1:0]  lat_code;
  logic        req;
  logic [2:0]  cmd;
  logic [23:0] addr;
  logic        busy;
  logic        done;
  logic        refused;
  logic [7:0]  rd_data;
  logic        active;
  logic [2:0]  last_cmd;
  int          fails = 0;
  int          n_checks = 0;
  int          rises = 0;
  // latency cycles by code, columns follow read_cmd_t
  int          lat_tab [0:3][0:5] = '{'{0, 8, 8, 8, 4, 4}, '{0, 8, 8, 8, 5, 4},
                                       '{0, 8, 8, 8, 6, 5}, '{0, 0, 0, 0, 4, 1}};

  // clock generator
  always #10 ref_clk = ~ref_clk;

  flash_link flash_link_inst ();

  flash_read_host #(.SCK_DIV(DIV)) flash_read_host_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .lat_code(lat_code), .req(req), .cmd(cmd), .addr(addr),
    .link(flash_link_inst), .busy(busy), .done(done), .refused(refused), .rd_data(rd_data));

  flash_read_device flash_read_device_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .lat_code(lat_code), .link(flash_link_inst),
    .active(active), .last_cmd(last_cmd));

  flash_link_props #(.HALF(DIV)) flash_link_props_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .sck(flash_link_inst.sck), .cs_n(flash_link_inst.cs_n),
    .host_oe(flash_link_inst.host_oe), .dev_oe(flash_link_inst.dev_oe), .io(flash_link_inst.io));

  // serial clock rises seen on the wire
  always @(posedge flash_link_inst.sck) begin
    rises++;
  end

  task automatic conclude();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD byte t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD flag t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_count(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD count t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // wire clocks: opcode, address, mode, dummy, data
  function automatic logic [7:0] exp_rises(input int c, input int k);
    int aw;
    int dw;
    aw = (k == 5) ? 4 : (k == 4) ? 2 : 1;
    dw = (k == 3 || k == 5) ? 4 : (k == 2 || k == 4) ? 2 : 1;
    return 8'(8 + 24 / aw + ((k == 5) ? 2 : 0) + lat_tab[c][k] + 8 / dw);
  endfunction

  // one read request, entered just after a clock edge
  task automatic do_read(input logic [1:0] c, input logic [2:0] k, input logic [23:0] a,
                         input logic sup, output logic ok, output logic [7:0] data);
    int n;
    @(posedge ref_clk);
    #1 lat_code = c;
    cmd = k;
    addr = a;
    req = 1'b1;
    rises = 0;
    @(posedge ref_clk);
    #1 req = 1'b0;
    for (n = 0; n < 4000 && done !== 1'b1 && refused !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    if (n >= 4000) begin
      fails++;
      conclude();
    end
    ok = (done === 1'b1);
    data = rd_data;
    chk_flag(refused, ~sup);
    chk_flag(active, sup);
    for (n = 0; n < 100 && busy !== 1'b0; n++) begin
      @(posedge ref_clk);
      #1;
    end
    if (n >= 100) begin
      fails++;
      conclude();
    end
  endtask

  // main sequence: every code against every command kind, back to back
  initial begin
    logic        ok;
    logic [7:0]  data;
    logic [23:0] a;
    logic        sup;
    rst_n = 1'b0;
    req = 1'b0;
    cmd = 3'h0;
    addr = 24'h000000;
    lat_code = 2'h3;
    repeat (6) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    chk_flag(flash_link_inst.cs_n, 1'b1);
    chk_flag(busy, 1'b0);
    chk_flag(active, 1'b0);
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 8; k++) begin
        a = 24'h12a5c3 + 24'h010317 * 24'(c * 8 + k);
        sup = (k <= 5) && !(k == 0 && c != 3);
        do_read(2'(c), 3'(k), a, sup, ok, data);
        chk_flag(ok, sup);
        if (sup) begin
          chk_byte(data, a[7:0] ^ a[15:8] ^ CONTENT_SEED);
          chk_count(8'(rises), exp_rises(c, k));
          chk_byte({5'h0, last_cmd}, {5'h0, 3'(k)});
        end else begin
          chk_count(8'(rises), 8'h00);
        end
      end
    end
    chk_flag(active, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
